/* include/dst_pkg.sv */
// constants, types and helpers shared by the threshold and readout logic
package dst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int CH_NUM = 32;
  localparam int BANK_NUM = 4;
  localparam int BANK_W = 8;
  localparam int FIELD_W = 6;
  localparam int THR_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // timing: master reset qualification
  localparam int CLK_NS = 10;
  localparam int MR_MIN_NS = 100;
  localparam int MR_MIN_CYC = (MR_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int MR_CNT_W = $clog2(MR_MIN_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // serial opcodes
  localparam logic [7:0] OP_WR_CTL = 8'h02;
  localparam logic [7:0] OP_WR_BANK = 8'h04;
  localparam logic [7:0] OP_WR_GND = 8'h3a;
  localparam logic [7:0] OP_WR_SUP = 8'h3c;
  localparam logic [7:0] OP_WR_TPAT = 8'h1e;
  localparam logic [7:0] OP_RD_CTL = 8'h82;
  localparam logic [7:0] OP_RD_BANK = 8'h84;
  localparam logic [7:0] OP_RD_GND = 8'hba;
  localparam logic [7:0] OP_RD_SUP = 8'hbc;
  localparam logic [7:0] OP_RD_TPAT = 8'h9e;
  localparam logic [7:0] OP_RD_B0 = 8'h90;
  localparam logic [7:0] OP_RD_B1 = 8'h92;
  localparam logic [7:0] OP_RD_B2 = 8'h94;
  localparam logic [7:0] OP_RD_B3 = 8'h96;
  localparam logic [7:0] OP_RD_ALL = 8'hf8;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int OP_RD_BIT = 7;
  localparam int CTL_TEST_BIT = 0;
  localparam int CTL_SOFT_RESET_FLAG_BIT = 1;
  localparam int PAT_ALL_LO = 0;
  localparam int PAT_ALL_HI = 1;
  localparam int PAT_ODD_LO = 2;
  localparam int PAT_ODD_HI = 3;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [CH_NUM-1:0] ODD_MASK = 32'haaaa_aaaa;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    SPI_OPCODE = 2'b00,
    SPI_WRITE = 2'b01,
    SPI_READ = 2'b10,
    SPI_DONE = 2'b11
  } dst_spi_t;

  typedef struct packed {
    logic [THR_W-1:0] upper;
    logic [THR_W-1:0] lower;
  } dst_thr_t;

  typedef struct packed {
    logic sck_m, sck_s, sck_p;
    logic csn_m, csn_s;
    logic si_m, si_s;
    logic mr_m, mr_s;
    logic [MR_CNT_W-1:0] mr_cnt;
    dst_spi_t spi;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] opcode;
    logic [7:0] shin;
    logic [31:0] shout;
    logic sdo;
    logic sdo_oe;
    logic [7:0] ctl, bank, tpat;
    logic [7:0] gnd_hys, gnd_cen, sup_hys, sup_cen;
    dst_thr_t [BANK_NUM-1:0] thr;
  } dst_main_t;

  typedef struct packed {
    logic [CH_NUM-1:0] up_m, up_s;
    logic [CH_NUM-1:0] lo_m, lo_s;
    logic [CH_NUM-1:0] status;
  } dst_stat_t;

  ////////////////////////////////////////////////////////////////////////////
  // window edges in half-volt codes: half the width in volts is width codes
  function automatic dst_thr_t dst_derive(input logic [7:0] hys,
                                          input logic [7:0] cen);
    logic [THR_W-1:0] h;
    logic [THR_W-1:0] c;
    dst_thr_t r; // result pair
    h = {1'b0, hys[FIELD_W-1:0]};
    c = {1'b0, cen[FIELD_W-1:0]};
    r.upper = c + h;
    // lower edge clamps at zero rather than wrapping
    r.lower = (c > h) ? c - h : '0;
    return r;
  endfunction

  // data bytes carried by a write opcode, zero for unknown ones
  function automatic logic [2:0] dst_wr_bytes(input logic [7:0] op);
    case (op)
      OP_WR_CTL, OP_WR_BANK, OP_WR_TPAT: dst_wr_bytes = 3'h1;
      OP_WR_GND, OP_WR_SUP: dst_wr_bytes = 3'h2;
      default: dst_wr_bytes = 3'h0;
    endcase
  endfunction

endpackage

/* hw/dst_status_map.sv */
// comparator result capture, self-test forcing and status word hold
`timescale 1ns/1ps
module dst_status_map
  import dst_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // control from the register side
  input wire logic clr_in,
  input wire logic test_en_in,
  input wire logic [3:0] pattern_in,
  // analog comparator results, asynchronous
  input wire logic [CH_NUM-1:0] above_upper_in,
  input wire logic [CH_NUM-1:0] below_lower_in,
  // status word
  output logic [CH_NUM-1:0] status_out
);

  dst_stat_t st_reg; // all state
  dst_stat_t st_next; // next state
  logic [CH_NUM-1:0] force_hi; // forced high inputs
  logic [CH_NUM-1:0] force_lo; // forced low inputs
  logic [CH_NUM-1:0] eff_up; // effective above-upper
  logic [CH_NUM-1:0] eff_lo; // effective below-lower

  ////////////////////////////////////////////////////////////////////////////
  // forced comparator inputs, highest pattern bit wins
  always_comb begin
    force_hi = '0;
    force_lo = '1;
    if (pattern_in[PAT_ODD_HI]) begin
      force_hi = ODD_MASK;
      force_lo = ~ODD_MASK;
    end else if (pattern_in[PAT_ODD_LO]) begin
      force_hi = ~ODD_MASK;
      force_lo = ODD_MASK;
    end else if (pattern_in[PAT_ALL_HI]) begin
      force_hi = '1;
      force_lo = '0;
    end
  end

  // a high input sits above the upper edge, a low one below the lower
  assign eff_up = test_en_in ? force_hi : st_reg.up_s;
  assign eff_lo = test_en_in ? force_lo : st_reg.lo_s;

  ////////////////////////////////////////////////////////////////////////////
  // next state: synchronisers and windowed status
  always_comb begin
    st_next = st_reg;
    // two flops per comparator line
    st_next.up_m = above_upper_in;
    st_next.up_s = st_reg.up_m;
    st_next.lo_m = below_lower_in;
    st_next.lo_s = st_reg.lo_m;
    // low side sets, high side clears, between keeps
    st_next.status = (st_reg.status & ~eff_up) | eff_lo;
    if (clr_in) begin
      st_next.status = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status_out = st_reg.status;

endmodule

/* hw/dst_sense_ctrl.sv */
// serial register access, resets and threshold derivation for 32 inputs
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - gnd width field sets gnd hysteresis
// - gnd center field sets gnd center
// - supply width field sets supply hysteresis
// - supply center field sets supply center
// - spare bits 7:6 stored, read, reset
// - 0x3A writes gnd pair, width first
// - 0xBC reads, 0x3C writes supply pair
// - edges are center plus/minus half width
// - gnd input low reads 1, open 0
// - supply input open 1, high 0
// - status word read by five commands
// - 0x90..0x96 one bank, 0xF8 all
// - 32 channels in 4 banks readable
// - bank type 0 gnd, 1 supply
// - type bit n covers bank n
// - two threshold pairs applied independently
// - power-up resets every register
// - master reset pin low resets all
// - soft reset bit holds reset until cleared
// - test bit forces comparator inputs
// - pattern selects forcing, read normally
// - pattern bits: odd hi/lo, all hi/lo
module dst_sense_ctrl
  import dst_pkg::*;
(
  // clock and power-up reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // master reset pin, asynchronous
  input wire logic master_reset_n_in,
  // serial port, mode 0, asynchronous pins
  input wire logic sck_in,
  input wire logic csn_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // analog comparator results per input
  input wire logic [CH_NUM-1:0] above_upper_in,
  input wire logic [CH_NUM-1:0] below_lower_in,
  // threshold codes toward each bank's converter
  output logic [BANK_NUM-1:0][THR_W-1:0] upper_threshold_out,
  output logic [BANK_NUM-1:0][THR_W-1:0] lower_threshold_out,
  // configuration and state shown outward
  output logic [BANK_NUM-1:0] bank_type_select_out,
  output logic self_test_out,
  output logic soft_reset_flag_out,
  output logic [CH_NUM-1:0] sense_status_out
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  dst_main_t st_reg; // all state
  dst_main_t st_next; // next state
  logic sck_rise; // sampled clock rose
  logic sck_fall; // sampled clock fell
  logic [7:0] rx_byte; // byte completed on this rise
  logic full_rst; // master reset qualified
  logic hold_rst; // master or soft reset holding the block
  logic [CH_NUM-1:0] status; // current status word
  logic [31:0] rd_word; // read data, msb first

  //////////////////////////////////////////////////////////////////////////
  // edge and reset decode, all from second synchroniser flops
  assign sck_rise = st_reg.sck_s & ~st_reg.sck_p;
  assign sck_fall = ~st_reg.sck_s & st_reg.sck_p;
  assign rx_byte = {st_reg.shin[6:0], st_reg.si_s};
  // pin held low long enough counts as a full reset
  assign full_rst = (st_reg.mr_cnt == MR_CNT_W'(MR_MIN_CYC));
  // soft reset keeps the status side cleared too
  assign hold_rst = full_rst | st_reg.ctl[CTL_SOFT_RESET_FLAG_BIT];

  //////////////////////////////////////////////////////////////////////////
  // read data picked at the opcode's last rising edge
  always_comb begin
    rd_word = '0;
    case (rx_byte)
      // single-byte registers sit in the top byte
      OP_RD_CTL: rd_word[31:24] = st_reg.ctl;
      OP_RD_BANK: rd_word[31:24] = st_reg.bank;
      OP_RD_TPAT: rd_word[31:24] = st_reg.tpat;
      // pairs go width byte first, spare bits included
      OP_RD_GND: rd_word[31:16] = {st_reg.gnd_hys, st_reg.gnd_cen};
      OP_RD_SUP: rd_word[31:16] = {st_reg.sup_hys, st_reg.sup_cen};
      // one bank per command
      OP_RD_B0: rd_word[31:24] = status[7:0];
      OP_RD_B1: rd_word[31:24] = status[15:8];
      OP_RD_B2: rd_word[31:24] = status[23:16];
      OP_RD_B3: rd_word[31:24] = status[31:24];
      // whole word, bit 31 first
      OP_RD_ALL: rd_word = status;
      // reserved opcodes return zeros
      default: rd_word = '0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    st_next = st_reg;

    // pin synchronisers, two flops each
    st_next.sck_m = sck_in;
    st_next.sck_s = st_reg.sck_m;
    st_next.sck_p = st_reg.sck_s;
    st_next.csn_m = csn_n_in;
    st_next.csn_s = st_reg.csn_m;
    st_next.si_m = sdi_in;
    st_next.si_s = st_reg.si_m;
    st_next.mr_m = master_reset_n_in;
    st_next.mr_s = st_reg.mr_m;

    // low time of the master reset pin, saturating
    if (st_reg.mr_s) begin
      st_next.mr_cnt = '0;
    end else if (!full_rst) begin
      st_next.mr_cnt = st_reg.mr_cnt + 1'b1;
    end

    // deselect ends the instruction, a partial byte is dropped
    if (st_reg.csn_s) begin
      st_next.spi = SPI_OPCODE;
      st_next.bit_cnt = '0;
      st_next.byte_cnt = '0;
      st_next.sdo = 1'b0;
      st_next.sdo_oe = 1'b0;
    end else if (sck_rise) begin
      // input bits are taken only while receiving
      if (st_reg.spi == SPI_OPCODE || st_reg.spi == SPI_WRITE) begin
        st_next.shin = rx_byte;
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        if (st_reg.bit_cnt == 3'h7) begin
          case (st_reg.spi)
            // opcode complete
            SPI_OPCODE: begin
              st_next.opcode = rx_byte;
              st_next.byte_cnt = '0;
              if (rx_byte[OP_RD_BIT]) begin
                st_next.spi = SPI_READ;
                st_next.shout = rd_word;
              end else if (dst_wr_bytes(rx_byte) != 3'h0) begin
                st_next.spi = SPI_WRITE;
              end else begin
                // unknown write: ignore the rest
                st_next.spi = SPI_DONE;
              end
            end
            // data byte complete: load its register now
            SPI_WRITE: begin
              case (st_reg.opcode)
                OP_WR_CTL: begin
                  st_next.ctl = rx_byte;
                end
                OP_WR_BANK: begin
                  st_next.bank = rx_byte;
                end
                OP_WR_TPAT: begin
                  st_next.tpat = rx_byte;
                end
                OP_WR_GND: begin
                  // width byte first, center byte second
                  if (st_reg.byte_cnt == 3'h0) begin
                    st_next.gnd_hys = rx_byte;
                  end else begin
                    st_next.gnd_cen = rx_byte;
                  end
                end
                OP_WR_SUP: begin
                  // same order for the supply pair
                  if (st_reg.byte_cnt == 3'h0) begin
                    st_next.sup_hys = rx_byte;
                  end else begin
                    st_next.sup_cen = rx_byte;
                  end
                end
                default: begin
                  st_next.spi = SPI_DONE;
                end
              endcase
              st_next.byte_cnt = st_reg.byte_cnt + 3'h1;
              // extra bytes after the last are ignored
              if (st_reg.byte_cnt + 3'h1 == dst_wr_bytes(st_reg.opcode)) begin
                st_next.spi = SPI_DONE;
              end
            end
            default: begin
              st_next.spi = SPI_DONE;
            end
          endcase
        end
      end
    end else if (sck_fall && st_reg.spi == SPI_READ) begin
      // output changes on falling edges, msb first, zeros after
      st_next.sdo = st_reg.shout[31];
      st_next.shout = {st_reg.shout[30:0], 1'b0};
      st_next.sdo_oe = 1'b1;
    end

    // each bank takes the pair of its own type
    for (int b = 0; b < BANK_NUM; b++) begin
      if (st_reg.bank[b]) begin
        st_next.thr[b] = dst_derive(st_reg.sup_hys, st_reg.sup_cen);
      end else begin
        st_next.thr[b] = dst_derive(st_reg.gnd_hys, st_reg.gnd_cen);
      end
    end

    // soft reset: other registers and test bit held at defaults
    if (st_next.ctl[CTL_SOFT_RESET_FLAG_BIT]) begin
      st_next.ctl[CTL_TEST_BIT] = 1'b0;
      st_next.bank = REG_RST;
      st_next.tpat = REG_RST;
      st_next.gnd_hys = REG_RST;
      st_next.gnd_cen = REG_RST;
      st_next.sup_hys = REG_RST;
      st_next.sup_cen = REG_RST;
    end

    // master reset: everything back to defaults, port idle
    if (full_rst) begin
      st_next.ctl = REG_RST;
      st_next.bank = REG_RST;
      st_next.tpat = REG_RST;
      st_next.gnd_hys = REG_RST;
      st_next.gnd_cen = REG_RST;
      st_next.sup_hys = REG_RST;
      st_next.sup_cen = REG_RST;
      st_next.spi = SPI_DONE;
      st_next.sdo = 1'b0;
      st_next.sdo_oe = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register, power-up reset to all defaults
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // comparator capture, forcing and status hold
  dst_status_map u_status (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .clr_in(hold_rst),
    .test_en_in(st_reg.ctl[CTL_TEST_BIT]),
    .pattern_in(st_reg.tpat[3:0]),
    .above_upper_in(above_upper_in),
    .below_lower_in(below_lower_in),
    .status_out(status)
  );

  //////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  always_comb begin
    for (int b = 0; b < BANK_NUM; b++) begin
      upper_threshold_out[b] = st_reg.thr[b].upper;
      lower_threshold_out[b] = st_reg.thr[b].lower;
    end
  end

  assign sdo_out = st_reg.sdo;
  assign sdo_oe_out = st_reg.sdo_oe;
  assign bank_type_select_out = st_reg.bank[BANK_NUM-1:0];
  assign self_test_out = st_reg.ctl[CTL_TEST_BIT];
  assign soft_reset_flag_out = st_reg.ctl[CTL_SOFT_RESET_FLAG_BIT];
  assign sense_status_out = status;

endmodule

/* test/dst_sense_ctrl_monitor.sv */
// port checks for the sensor threshold and readout block
`timescale 1ns/1ps
module dst_sense_ctrl_monitor
  import dst_pkg::*;
(
  // clock and resets
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic master_reset_n_in,
  // serial select and data enable
  input wire logic csn_n_in,
  input wire logic sdo_oe_out,
  // comparator results
  input wire logic [CH_NUM-1:0] above_upper_in,
  input wire logic [CH_NUM-1:0] below_lower_in,
  // observed state
  input wire logic [BANK_NUM-1:0][THR_W-1:0] upper_threshold_out,
  input wire logic [BANK_NUM-1:0][THR_W-1:0] lower_threshold_out,
  input wire logic [BANK_NUM-1:0] bank_type_select_out,
  input wire logic self_test_out,
  input wire logic soft_reset_flag_out,
  input wire logic [CH_NUM-1:0] sense_status_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  //////////////////////////////////////////////////////////////////////////////
  // helper logic
  logic [4:0] mr_low_reg; // consecutive low samples of the pin reset
  logic all_clear; // threshold, status and bank type outputs all zero at once
  logic normal; // no self-test and no reset of any kind
  // counter saturates so a long pulse never wraps
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mr_low_reg <= 5'h00;
    end else if (master_reset_n_in) begin
      mr_low_reg <= 5'h00;
    end else if (mr_low_reg != 5'h1f) begin
      mr_low_reg <= mr_low_reg + 5'h01;
    end
  end
  assign all_clear = upper_threshold_out == '0 && lower_threshold_out == '0 &&
                     sense_status_out == '0 && bank_type_select_out == '0;
  assign normal = !self_test_out && !soft_reset_flag_out && master_reset_n_in;

  //////////////////////////////////////////////////////////////////////////////
  // comparator levels held long enough to cross the input flops
  sequence s_low_held;
    (below_lower_in[0] && normal) [*7];
  endsequence
  sequence s_high_held;
    (above_upper_in[31] && !below_lower_in[31] && normal) [*7];
  endsequence
  sequence s_quiet_held;
    (!above_upper_in[0] && !below_lower_in[0] && normal) [*7];
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  a_reset_clear: assert property ($rose(nrst_in) |-> all_clear && !self_test_out &&
    !soft_reset_flag_out && !sdo_oe_out) else $error("outputs not clear after reset");
  a_pin_reset: assert property (mr_low_reg >= 5'h10 |-> all_clear &&
    !self_test_out && !sdo_oe_out) else $error("pin reset did not clear state");
  a_soft_hold: assert property (soft_reset_flag_out [*4] |->
    all_clear && !self_test_out) else $error("soft reset does not hold state");
  a_low_sets: assert property (s_low_held |-> sense_status_out[0])
    else $error("low input did not set status");
  a_high_clears: assert property (s_high_held |-> !sense_status_out[31])
    else $error("high input did not clear status");
  a_keep_between: assert property (s_quiet_held |-> $stable(sense_status_out[0]))
    else $error("status moved between edges");
  a_test_forced: assert property (self_test_out [*6] |-> sense_status_out inside
    {32'h0, 32'hffff_ffff, ODD_MASK, ~ODD_MASK}) else $error("self-test word invalid");
  a_select_idle: assert property (csn_n_in [*8] |-> !sdo_oe_out)
    else $error("data out driven without select");
  // per bank window shape, and sharing with bank 0 for each bank of the same type
  for (genvar b = 0; b < BANK_NUM; b++) begin : g_bank
    a_window_even: assert property (lower_threshold_out[b] != '0 |->
      upper_threshold_out[b] >= lower_threshold_out[b] &&
      upper_threshold_out[b][0] == lower_threshold_out[b][0]) else $error("window shape bad");
    if (b > 0) begin : g_pair
      a_same_type: assert property ($stable(bank_type_select_out) &&
        bank_type_select_out[b] == bank_type_select_out[0] |->
        upper_threshold_out[b] == upper_threshold_out[0] &&
        lower_threshold_out[b] == lower_threshold_out[0]) else $error("same type differs");
    end
  end
endmodule

/* test/dst_spi_host.sv */
// host serial master model sending mode 0 instructions to the block
`timescale 1ns/1ps
module dst_spi_host (
  // pacing clock
  input wire logic ref_clk_in,
  // serial pins
  output logic sck_out,
  output logic csn_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  // idle: clock low, select high, data at its pull-down level
  initial begin
    sck_out = 1'b0;
    csn_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // one 80 ns bit, data out taken late in the high phase
  task automatic bit_cycle(input logic din, output logic dout);
    sdi_out = din;
    repeat (4) @(negedge ref_clk_in);
    sck_out = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    dout = sdo_in;
    sck_out = 1'b0;
  endtask

  // one instruction per select: opcode then data bytes, msb first
  task automatic xfer(input logic [7:0] op, input int nbytes,
                      input logic [31:0] wdata, output logic [31:0] rdata);
    logic b;
    logic [39:0] frame;
    rdata = '0;
    frame = {op, wdata << (8 * (4 - nbytes))};
    @(negedge ref_clk_in);
    csn_n_out = 1'b0;
    for (int i = 0; i < 8 + 8 * nbytes; i++) begin
      bit_cycle(frame[39-i], b);
      if (i >= 8) begin
        rdata = {rdata[30:0], b};
      end
    end
    repeat (4) @(negedge ref_clk_in);
    csn_n_out = 1'b1;
    sdi_out = 1'b0;
    repeat (8) @(negedge ref_clk_in);
  endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the sensor threshold and readout block
`timescale 1ns/1ps
module testbench
  import dst_pkg::*;
;
  // wiring
  logic ref_clk = 1'b0;
  logic nrst, mr_n, sck, csn_n, sdi, sdo, sdo_oe, stest, sflag;
  logic [CH_NUM-1:0] above, below, status;
  logic [BANK_NUM-1:0] btype;
  logic [BANK_NUM-1:0][THR_W-1:0] upper, lower;
  int err_count = 0;
  int cmp_count = 0;
  // row: write, then read back
  typedef struct packed {
    logic [7:0] wop;
    logic [2:0] n;
    logic [15:0] wdat;
    logic [7:0] rop;
    logic [15:0] exp;
  } dst_row_t;
  localparam dst_row_t ROWS [6] = '{
    '{OP_WR_GND, 3'h2, 16'hc60f, OP_RD_GND, 16'hc60f},
    '{OP_WR_SUP, 3'h2, 16'h4612, OP_RD_SUP, 16'h4612},
    '{OP_WR_BANK, 3'h1, 16'h000a, OP_RD_BANK, 16'h000a},
    '{OP_WR_TPAT, 3'h1, 16'h0008, OP_RD_TPAT, 16'h0008},
    '{OP_WR_CTL, 3'h1, 16'h00fc, OP_RD_CTL, 16'h00fc},
    '{8'h06, 3'h1, 16'h00ff, 8'h86, 16'h0000}};
  localparam logic [31:0] PAT_EXP [4] = '{32'hffff_ffff, 32'h0, ODD_MASK, ~ODD_MASK};

  always #5 ref_clk = ~ref_clk;

  dst_sense_ctrl i_dst_sense_ctrl (
    .ref_clk_in(ref_clk), .nrst_in(nrst), .master_reset_n_in(mr_n), .sck_in(sck),
    .csn_n_in(csn_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .above_upper_in(above), .below_lower_in(below), .upper_threshold_out(upper),
    .lower_threshold_out(lower), .bank_type_select_out(btype), .self_test_out(stest),
    .soft_reset_flag_out(sflag), .sense_status_out(status));
  // no pull on the data line: an undriven line reads inverted so a late enable shows
  dst_spi_host i_dst_spi_host (.ref_clk_in(ref_clk), .sck_out(sck), .csn_n_out(csn_n),
    .sdi_out(sdi), .sdo_in(sdo_oe ? sdo : ~sdo));

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic tally(input logic ok, input string what, input logic [31:0] got, exp);
    cmp_count++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    tally(got === exp, "read", got, exp);
  endtask
  task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
    tally(got === exp, "port", got, exp);
  endtask
  task automatic wr(input logic [7:0] op, input int n, input logic [31:0] v);
    logic [31:0] unused;
    i_dst_spi_host.xfer(op, n, v, unused);
  endtask
  task automatic rd(input logic [7:0] op, input int n, output logic [31:0] d);
    i_dst_spi_host.xfer(op, n, 32'h0, d);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    close_out();
  end

  // main sequence
  initial begin
    logic [31:0] d;
    logic [15:0] pair;
    logic [6:0] eu, el;
    nrst = 1'b0;
    mr_n = 1'b1;
    above = '0;
    below = '0;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    foreach (ROWS[i]) begin
      wr(ROWS[i].wop, int'(ROWS[i].n), {16'h0, ROWS[i].wdat});
      rd(ROWS[i].rop, int'(ROWS[i].n), d);
      chk_rd(d, {16'h0, ROWS[i].exp});
    end
    // edges per bank from its type's pair
    chk_port({28'h0, btype}, 32'h0000_000a);
    for (int b = 0; b < BANK_NUM; b++) begin
      pair = b[0] ? ROWS[1].wdat : ROWS[0].wdat;
      eu = {1'b0, pair[5:0]} + {1'b0, pair[13:8]};
      el = {1'b0, pair[5:0]} - {1'b0, pair[13:8]};
      chk_port(32'(upper[b]), 32'(eu));
      chk_port(32'(lower[b]), 32'(el));
    end
    // comparator levels: low sets, high clears, between keeps
    below = 32'h8000_00f0;
    above = 32'h0f00_000f;
    repeat (8) @(negedge ref_clk);
    chk_port(status, 32'h8000_00f0);
    rd(OP_RD_ALL, 4, d);
    chk_rd(d, 32'h8000_00f0);
    for (int k = 0; k < BANK_NUM; k++) begin
      rd(OP_RD_B0 + 8'(2 * k), 1, d);
      chk_rd(d, {24'h0, 8'(32'h8000_00f0 >> (8 * k))});
    end
    below = '0;
    above = 32'h8000_0000;
    repeat (8) @(negedge ref_clk);
    chk_port(status, 32'h0000_00f0);
    // self-test over every pattern bit
    wr(OP_WR_CTL, 1, 32'h1);
    chk_port(32'(stest), 32'h1);
    for (int p = 0; p < 4; p++) begin
      wr(OP_WR_TPAT, 1, 32'h1 << p);
      rd(OP_RD_ALL, 4, d);
      chk_rd(d, PAT_EXP[p]);
    end
    below = 32'h0000_ffff;
    above = 32'hffff_0000;
    wr(OP_WR_CTL, 1, 32'h0);
    repeat (8) @(negedge ref_clk);
    chk_port(status, 32'h0000_ffff);
    // soft reset clears registers and status and keeps them clear, writes ignored
    wr(OP_WR_CTL, 1, 32'h2);
    chk_port(32'(sflag), 32'h1);
    wr(OP_WR_GND, 2, 32'h0102);
    rd(OP_RD_GND, 2, d);
    chk_rd(d, 32'h0);
    rd(OP_RD_CTL, 1, d);
    chk_rd(d, 32'h2);
    chk_port(status, 32'h0);
    wr(OP_WR_CTL, 1, 32'h0);
    rd(OP_RD_SUP, 2, d);
    chk_rd(d, 32'h0);
    // worked example, then pin reset
    wr(OP_WR_GND, 2, 32'h060f);
    chk_port(32'(upper[0]), 32'h15);
    chk_port(32'(lower[0]), 32'h09);
    mr_n = 1'b0;
    repeat (20) @(negedge ref_clk);
    mr_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk_port(32'(upper[0]), 32'h0);
    foreach (ROWS[i]) begin
      rd(ROWS[i].rop, int'(ROWS[i].n), d);
      chk_rd(d, 32'h0);
    end
    close_out();
  end
endmodule

bind dst_sense_ctrl dst_sense_ctrl_monitor i_dst_sense_ctrl_monitor (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .master_reset_n_in(master_reset_n_in),
  .csn_n_in(csn_n_in), .sdo_oe_out(sdo_oe_out), .above_upper_in(above_upper_in),
  .below_lower_in(below_lower_in), .upper_threshold_out(upper_threshold_out),
  .lower_threshold_out(lower_threshold_out), .bank_type_select_out(bank_type_select_out),
  .self_test_out(self_test_out), .soft_reset_flag_out(soft_reset_flag_out),
  .sense_status_out(sense_status_out));
